// [hcwf_params.svh]
/*
  constants of the hopping code word framer: register offsets, field positions, timing.
  assumes a 50 MHz sys_clk and a 4-bit word address on the register port.
*/
`ifndef HCWF_PARAMS_SVH
`define HCWF_PARAMS_SVH
// ============================================================
// register word addresses
`define HCWF_ADDR_SYNC   4'h4
`define HCWF_ADDR_SER0   4'h6
`define HCWF_ADDR_SER1   4'h7
`define HCWF_ADDR_ENKEY  4'ha
`define HCWF_ADDR_CFG    4'hb
// ============================================================
// configuration word fields
`define HCWF_CFG_DISC_HI 9
`define HCWF_CFG_WRAP0   10
`define HCWF_CFG_WRAP1   11
`define HCWF_CFG_LVS     12
`define HCWF_CFG_RATE0   13
`define HCWF_CFG_RATE1   14
`define HCWF_CFG_FIXED_PART_CIPHER_SELECT    15
`define HCWF_CFG_RESET   16'h0000
// ============================================================
// timing
`define HCWF_CLK_MHZ     50
`define HCWF_TE_US       400
`define HCWF_ENTRY_US    3500
`define HCWF_PRE_TE      6'h18
`define HCWF_HDR_TE      6'h0a
`define HCWF_GUARD_TE    6'h27
`define HCWF_SUB_LAST    2'h2
`define HCWF_BIT_LAST    7'h41
`define HCWF_XBITS       7'h52
`define HCWF_SYNC_MAX    16'hffff
`endif

// [hcwf_pkg.sv]
/*
  types of the hopping code word framer.
  assumes nothing of its surroundings.
*/
`default_nettype none
package hcwf_pkg;
  // ============================================================
  // frame sequencer, gray along idle-build-preamble-header-data-guard
  typedef enum logic [2:0] {
    HCWF_IDLE  = 3'h0,
    HCWF_BUILD = 3'h1,
    HCWF_PRE   = 3'h3,
    HCWF_HDR   = 3'h2,
    HCWF_DATA  = 3'h6,
    HCWF_GUARD = 3'h7,
    HCWF_SYNC  = 3'h5,
    HCWF_SPARE = 3'h4
  } hcwf_state_t;
endpackage
`default_nettype wire

// [hcwf_framer.sv]
/*
  hopping code word framer: builds and sends the 66-bit code word, timed or externally clocked.
  assumes cipher engines outside answer combinationally on the same clock; pins are asynchronous.
*/
`include "hcwf_params.svh"
`timescale 1ns/1ps
`default_nettype none
module hcwf_framer #(
  parameter int TE_CYC    = `HCWF_TE_US * `HCWF_CLK_MHZ,
  parameter int ENTRY_CYC = `HCWF_ENTRY_US * `HCWF_CLK_MHZ
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // button and comparator pins
  input  wire logic        button_input_a,
  input  wire logic        button_input_b,
  input  wire logic        button_input_c_clock,
  input  wire logic [1:0]  shift_level,
  input  wire logic        trip_high_supply,
  input  wire logic        trip_low_supply,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // cipher engines
  output logic      [31:0] hop_plain,
  input  wire logic [31:0] hop_cipher,
  output logic      [31:0] env_plain,
  output logic      [15:0] env_key,
  input  wire logic [31:0] env_cipher,
  // link and status
  output logic             tx_data,
  output logic             low_battery_flag,
  output logic             awake
);
  // ============================================================
  // synchronisers
  logic [6:0] meta_reg, meta_next, pin_reg, pin_next;
  logic       a_s, b_s, c_s;
  logic [1:0] shift_s;
  assign meta_next = {trip_low_supply, trip_high_supply, shift_level,
                      button_input_c_clock, button_input_b, button_input_a};
  assign pin_next  = meta_reg;
  assign {a_s, b_s, c_s} = {pin_reg[0], pin_reg[1], pin_reg[2]};
  assign shift_s = pin_reg[4:3];

  // ============================================================
  // function code from buttons and shift level
  function automatic logic [3:0] hcwf_code(input logic [1:0] lvl, input logic c, input logic b,
                                           input logic a);
    logic [1:0] low;
    low = c ? 2'h3 : 2'({b, a} - 2'h1);
    return {lvl, low};
  endfunction

  // ============================================================
  // state
  hcwf_pkg::hcwf_state_t state_reg, state_next;
  logic [15:0] cfg_reg, cfg_next, sync_reg, sync_next, ser0_reg, ser0_next;
  logic [15:0] ser1_reg, ser1_next, key_reg, key_next, rdata_reg, rdata_next;
  logic [81:0] pay_reg, pay_next;
  logic [3:0]  func_reg, func_next;
  logic [2:0]  held_reg, held_next, btn;
  logic [14:0] div_reg, div_next, te_len;
  logic [5:0]  te_reg, te_next;
  logic [6:0]  bit_reg, bit_next;
  logic [1:0]  sub_reg, sub_next, slot_reg, slot_next, mask;
  logic [17:0] ent_reg, ent_next;
  logic        rpt_reg, rpt_next, smode_reg, smode_next, tx_reg, tx_next, c_q_reg;
  logic        tick, send_ok, c_fall, c_rise, sync_entry, fresh;
  assign low_battery_flag = cfg_reg[`HCWF_CFG_LVS] ? pin_reg[5] : pin_reg[6];

  assign btn     = {c_s, b_s, a_s};
  assign c_fall  = c_q_reg & ~c_s;
  assign c_rise  = ~c_q_reg & c_s;
  assign tick    = (div_reg == 15'h0000);
  assign fresh   = |(btn & ~held_reg);
  assign sync_entry = c_fall && (ent_reg >= 18'(ENTRY_CYC - 1)) && (a_s | b_s);
  always_comb begin
    unique case ({cfg_reg[`HCWF_CFG_RATE1], cfg_reg[`HCWF_CFG_RATE0]})
      2'h0: begin te_len = 15'(TE_CYC);      mask = 2'h0; end
      2'h1: begin te_len = 15'(TE_CYC / 2);  mask = 2'h1; end
      2'h2: begin te_len = 15'(TE_CYC / 4);  mask = 2'h1; end
      2'h3: begin te_len = 15'(TE_CYC / 4);  mask = 2'h3; end
    endcase
  end
  assign send_ok = ((slot_reg & mask) == 2'h0);

  assign hop_plain = {func_reg, cfg_reg[`HCWF_CFG_WRAP1], cfg_reg[`HCWF_CFG_WRAP0],
                      cfg_reg[`HCWF_CFG_DISC_HI:0], sync_reg};
  assign env_plain = {func_reg, ser1_reg[11:0], ser0_reg};
  assign env_key   = key_reg;
  assign reg_rdata = rdata_reg;
  assign tx_data   = tx_reg;
  assign awake     = (state_reg != hcwf_pkg::HCWF_IDLE);

  // ============================================================
  // next state
  always_comb begin
    logic start;
    logic [3:0] code;
    start      = 1'b0;
    code       = hcwf_code(shift_s, c_s, b_s, a_s);
    state_next = state_reg;
    cfg_next   = cfg_reg;
    sync_next  = sync_reg;
    ser0_next  = ser0_reg;
    ser1_next  = ser1_reg;
    key_next   = key_reg;
    pay_next   = pay_reg;
    func_next  = func_reg;
    held_next  = held_reg;
    te_next    = te_reg;
    bit_next   = bit_reg;
    sub_next   = sub_reg;
    slot_next  = slot_reg;
    rpt_next   = rpt_reg;
    smode_next = smode_reg;
    tx_next    = 1'b0;
    rdata_next = 16'h0000;
    div_next   = tick ? 15'(te_len - 15'h0001) : 15'(div_reg - 15'h0001);
    ent_next   = c_s ? ((&ent_reg) ? ent_reg : 18'(ent_reg + 18'h00001)) : 18'h00000;
    if (reg_rd) begin
      unique case (reg_addr)
        `HCWF_ADDR_CFG:   rdata_next = cfg_reg;
        `HCWF_ADDR_SYNC:  rdata_next = sync_reg;
        `HCWF_ADDR_SER0:  rdata_next = ser0_reg;
        `HCWF_ADDR_SER1:  rdata_next = ser1_reg;
        `HCWF_ADDR_ENKEY: rdata_next = key_reg;
        default:          rdata_next = 16'h0000;
      endcase
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `HCWF_ADDR_CFG:   cfg_next  = reg_wdata;
        `HCWF_ADDR_SYNC:  sync_next = reg_wdata;
        `HCWF_ADDR_SER0:  ser0_next = reg_wdata;
        `HCWF_ADDR_SER1:  ser1_next = reg_wdata;
        `HCWF_ADDR_ENKEY: key_next  = reg_wdata;
        default:          ;
      endcase
    end
    unique case (state_reg)
      hcwf_pkg::HCWF_IDLE: begin
        slot_next = 2'h0;
        rpt_next  = 1'b0;
        if (|btn) start = 1'b1;
      end
      hcwf_pkg::HCWF_BUILD: begin
        pay_next = {16'h0000, rpt_reg, low_battery_flag,
                    cfg_reg[`HCWF_CFG_FIXED_PART_CIPHER_SELECT] ? env_cipher : env_plain, hop_cipher};
        te_next  = 6'h00;
        bit_next = 7'h00;
        sub_next = 2'h0;
        div_next = 15'(te_len - 15'h0001);
        state_next = smode_reg ? hcwf_pkg::HCWF_SYNC : hcwf_pkg::HCWF_PRE;
      end
      hcwf_pkg::HCWF_PRE: begin
        tx_next = send_ok & ~te_reg[0];
        if (tick) begin
          te_next = 6'(te_reg + 6'h01);
          if (te_reg == `HCWF_PRE_TE - 6'h01) begin
            te_next = 6'h00;
            state_next = hcwf_pkg::HCWF_HDR;
          end
        end
      end
      hcwf_pkg::HCWF_HDR: begin
        if (tick) begin
          te_next = 6'(te_reg + 6'h01);
          if (te_reg == `HCWF_HDR_TE - 6'h01) state_next = hcwf_pkg::HCWF_DATA;
        end
      end
      hcwf_pkg::HCWF_DATA: begin
        // one is a short high element, zero a long one
        tx_next = send_ok & ((sub_reg == 2'h0) | ((sub_reg == 2'h1) & ~pay_reg[0]));
        if (tick) begin
          sub_next = 2'(sub_reg + 2'h1);
          if (sub_reg == `HCWF_SUB_LAST) begin
            sub_next = 2'h0;
            pay_next = {1'b0, pay_reg[81:1]};
            bit_next = 7'(bit_reg + 7'h01);
            if (bit_reg == `HCWF_BIT_LAST) begin
              te_next = 6'h00;
              state_next = hcwf_pkg::HCWF_GUARD;
            end
          end
        end
      end
      hcwf_pkg::HCWF_GUARD: begin
        if (tick) begin
          te_next = 6'(te_reg + 6'h01);
          if (te_reg == `HCWF_GUARD_TE - 6'h01) begin
            slot_next = 2'(slot_reg + 2'h1);
            if (|btn) begin
              start = 1'b1;
              rpt_next = 1'b1;
            end else begin
              state_next = hcwf_pkg::HCWF_IDLE;
            end
          end
        end
      end
      hcwf_pkg::HCWF_SYNC: begin
        tx_next = tx_reg;
        if (c_rise) begin
          if (bit_reg == `HCWF_XBITS) begin
            tx_next = 1'b0;
            smode_next = 1'b0;
            state_next = hcwf_pkg::HCWF_IDLE;
          end else begin
            tx_next  = pay_reg[0];
            pay_next = {1'b0, pay_reg[81:1]};
            bit_next = 7'(bit_reg + 7'h01);
          end
        end
      end
      default: state_next = hcwf_pkg::HCWF_IDLE;
    endcase
    if (fresh && state_reg inside {hcwf_pkg::HCWF_PRE, hcwf_pkg::HCWF_HDR, hcwf_pkg::HCWF_DATA,
                                   hcwf_pkg::HCWF_GUARD}) begin
      start = 1'b1;
      rpt_next = 1'b0;
    end
    // clocked mode takes precedence over a timed word in flight
    if (sync_entry && state_reg != hcwf_pkg::HCWF_SYNC) begin
      start = 1'b1;
      smode_next = 1'b1;
      rpt_next = 1'b0;
      code = hcwf_code(shift_s, 1'b0, b_s, a_s);
    end
    if (start) begin
      func_next = code;
      held_next = btn;
      sync_next = 16'(sync_reg + 16'h0001);
      if (sync_reg == `HCWF_SYNC_MAX) begin
        if (cfg_reg[`HCWF_CFG_WRAP0]) cfg_next[`HCWF_CFG_WRAP0] = 1'b0;
        else cfg_next[`HCWF_CFG_WRAP1] = 1'b0;
      end
      state_next = hcwf_pkg::HCWF_BUILD;
    end
    // the clocked word is ready two cycles after entry, far below one clock period
  end

  // ============================================================
  // registers
  always_ff @(posedge sys_clk) begin
    meta_reg <= meta_next;
    pin_reg  <= pin_next;
    if (rst) begin
      state_reg <= hcwf_pkg::HCWF_IDLE;
      cfg_reg   <= `HCWF_CFG_RESET;
      sync_reg  <= 16'h0000;
      ser0_reg  <= 16'h0000;
      ser1_reg  <= 16'h0000;
      key_reg   <= 16'h0000;
      rdata_reg <= 16'h0000;
      pay_reg   <= 82'h0;
      func_reg  <= 4'h0;
      held_reg  <= 3'h0;
      div_reg   <= 15'h0000;
      te_reg    <= 6'h00;
      bit_reg   <= 7'h00;
      sub_reg   <= 2'h0;
      slot_reg  <= 2'h0;
      ent_reg   <= 18'h00000;
      rpt_reg   <= 1'b0;
      smode_reg <= 1'b0;
      tx_reg    <= 1'b0;
      c_q_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cfg_reg   <= cfg_next;
      sync_reg  <= sync_next;
      ser0_reg  <= ser0_next;
      ser1_reg  <= ser1_next;
      key_reg   <= key_next;
      rdata_reg <= rdata_next;
      pay_reg   <= pay_next;
      func_reg  <= func_next;
      held_reg  <= held_next;
      div_reg   <= div_next;
      te_reg    <= te_next;
      bit_reg   <= bit_next;
      sub_reg   <= sub_next;
      slot_reg  <= slot_next;
      ent_reg   <= ent_next;
      rpt_reg   <= rpt_next;
      smode_reg <= smode_next;
      tx_reg    <= tx_next;
      c_q_reg   <= c_s;
    end
  end

  // ============================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_disc_in_block: assert property (hop_plain[25:16] == cfg_reg[`HCWF_CFG_DISC_HI:0])
    else $error("discrimination value missing from cipher block");
  a_wrap_first: assert property (state_next == hcwf_pkg::HCWF_BUILD && state_reg != hcwf_pkg::HCWF_BUILD
      && sync_reg == `HCWF_SYNC_MAX && cfg_reg[`HCWF_CFG_WRAP0] && !reg_wr
      |=> !cfg_reg[`HCWF_CFG_WRAP0] && cfg_reg[`HCWF_CFG_WRAP1] == $past(cfg_reg[`HCWF_CFG_WRAP1]))
    else $error("first wrap flag not cleared alone");
  a_wrap_sticky: assert property (!cfg_reg[`HCWF_CFG_WRAP1] && !reg_wr |=> !cfg_reg[`HCWF_CFG_WRAP1])
    else $error("wrap flag set by hardware");
  a_sync_step: assert property (state_reg != hcwf_pkg::HCWF_BUILD && state_next == hcwf_pkg::HCWF_BUILD
      && !reg_wr |=> sync_reg == 16'($past(sync_reg) + 16'h0001))
    else $error("sync value not advanced");
  a_blank_slot: assert property (!send_ok && state_reg inside {hcwf_pkg::HCWF_PRE, hcwf_pkg::HCWF_DATA}
      |=> !tx_data)
    else $error("output active in blanked slot");
  a_word_len: assert property (state_reg == hcwf_pkg::HCWF_DATA && tick && sub_reg == `HCWF_SUB_LAST
      && bit_reg == `HCWF_BIT_LAST && !fresh && !sync_entry |=> state_reg == hcwf_pkg::HCWF_GUARD)
    else $error("data phase length wrong");
  a_abort_new: assert property (fresh && state_reg == hcwf_pkg::HCWF_DATA |=> state_reg == hcwf_pkg::HCWF_BUILD)
    else $error("new button did not abort");
  a_sync_enter: assert property (sync_entry |=> smode_reg ##1 state_reg == hcwf_pkg::HCWF_SYNC)
    else $error("sync mode not entered");
  a_rate_fast: assert property (cfg_reg[`HCWF_CFG_RATE1] |-> te_len == 15'(TE_CYC / 4))
    else $error("pulse element wrong");
  c_sync_mode: cover property (state_reg == hcwf_pkg::HCWF_SYNC && c_rise);
  c_repeat:    cover property (rpt_reg && state_reg == hcwf_pkg::HCWF_PRE);
  c_abort:     cover property (fresh && state_reg == hcwf_pkg::HCWF_DATA);
  c_blanked:   cover property (!send_ok && state_reg == hcwf_pkg::HCWF_PRE);
endmodule
`default_nettype wire

// [hcwf_rf_rx.sv]
/*
  rf stage and remote receiver model: decodes the timed code word seen on tx_data.
  assumes the bench tells it the pulse element length in sys_clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module hcwf_rf_rx (
  // clock
  input  wire logic        sys_clk,
  // link
  input  wire logic        tx_data,
  input  wire logic [15:0] te_cyc,
  // decoded word
  output logic             word_valid,
  output logic      [65:0] word,
  output logic             gap_short
);
  int   t;
  int   since_rise;
  int   since_end;
  int   idx;
  int   ph;
  int   k;
  logic in_frame;
  logic tx_q;
  logic exp_lvl;
  initial begin
    {in_frame, tx_q, word_valid, gap_short, word} = '0;
    t = 0;
    since_rise = 0;
    since_end = 1 << 20;
  end
  // ============================================================
  // frame decoder, samples mid element
  always @(posedge sys_clk) begin
    word_valid <= 1'b0;
    gap_short <= 1'b0;
    since_rise = (tx_data && !tx_q) ? 0 : since_rise + 1;
    since_end = since_end + 1;
    if (tx_data && !tx_q && !in_frame) begin
      in_frame = 1'b1;
      t = 0;
      gap_short <= since_end < 39 * te_cyc;
    end else if (in_frame) begin
      t = t + 1;
    end
    tx_q = tx_data;
    if (in_frame && t % te_cyc == te_cyc / 2) begin
      idx = t / te_cyc;
      ph = (idx - 34) % 3;
      k = (idx - 34) / 3;
      exp_lvl = idx < 24 ? !idx[0] : idx < 34 ? 1'b0 : ph == 0;
      if (idx >= 34 && ph == 1) begin
        word[k] <= !tx_data;
      end else if (tx_data !== exp_lvl) begin
        // an aborted word restarts from the latest rise, which may be a new preamble
        in_frame = tx_data;
        t = since_rise;
      end else if (k == 65 && ph == 2) begin
        word_valid <= 1'b1;
        in_frame = 1'b0;
        since_end = 0;
      end
    end
  end
endmodule
`default_nettype wire

// [hcwf_framer_tb.sv]
/*
  testbench of the code word framer: registers, timed words, abort, wrap, sync mode, blanking.
  assumes the framer and the receiver model; the cipher engines are simple stand-ins here.
*/
`include "hcwf_params.svh"
`timescale 1ns/1ps
`default_nettype none
module hcwf_framer_tb;
  localparam int TE = 8;
  logic        sys_clk, rst, a, b, c, trip_hi, trip_lo, reg_wr, reg_rd;
  logic        tx_data, low_bat, awake, rx_valid, gap_short;
  logic [1:0]  shift;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, env_key, te_cyc, cfg, sync_v, ser0, ser1, ekey;
  logic [31:0] hop_plain, hop_cipher, env_plain, env_cipher;
  logic [65:0] rx_word;
  logic [81:0] exp82, got;
  logic [81:0] exp_q[$];
  logic [15:0] rd_q[$];
  int          mismatches, checks, cyc, rx_n, n;
  bit          check_on, rd_pend;

  function automatic logic [31:0] hop_f(logic [31:0] p);
    return {p[7:0], p[31:8]} ^ 32'h6e2b91d4;
  endfunction
  assign hop_cipher = hop_f(hop_plain);
  assign env_cipher = ~env_plain ^ {env_key, env_key};

  hcwf_framer #(.TE_CYC(TE), .ENTRY_CYC(16)) i_hcwf_framer (
    .sys_clk, .rst, .button_input_a(a), .button_input_b(b), .button_input_c_clock(c),
    .shift_level(shift), .trip_high_supply(trip_hi), .trip_low_supply(trip_lo),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hop_plain, .hop_cipher,
    .env_plain, .env_key, .env_cipher, .tx_data, .low_battery_flag(low_bat), .awake);
  hcwf_rf_rx i_hcwf_rf_rx (.sys_clk, .tx_data, .te_cyc, .word_valid(rx_valid), .word(rx_word), .gap_short);

  // ============================================================
  // helpers
  function automatic logic [65:0] exp_w(logic [3:0] f, logic rep);
    logic [31:0] x;
    x = {f, ser1[11:0], ser0};
    if (cfg[15]) x = ~x ^ {ekey, ekey};
    return {rep, cfg[12] ? trip_hi : trip_lo, x, hop_f({f, cfg[11:0], sync_v})};
  endfunction
  task automatic chk(string what, logic [81:0] e, logic [81:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(logic [3:0] ad, logic [15:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // one idle edge, so a following call never assigns a strobe twice in one step
    @(posedge sys_clk);
  endtask
  task automatic rd(logic [3:0] ad, logic [15:0] e);
    rd_q.push_back(e);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_rx(int n);
    for (int w = 0; w < 4000 * TE && (rx_n < n || awake !== 1'b0); w++) @(posedge sys_clk);
    chk("words then idle", {n, 1'b0}, {rx_n, awake});
  endtask
  // note expected words, press, release after hold cycles, wait for all of them
  task automatic word(logic [2:0] bt, logic [3:0] f, int hold, int reps);
    int n;
    n = rx_n + reps;
    for (int r = 0; r < reps; r++) begin
      sync_v++;
      if (sync_v == 0) cfg[11:10] = cfg[10] ? {cfg[11], 1'b0} : 2'b00;
      exp_q.push_back(exp_w(f, r != 0));
    end
    {c, b, a} <= bt;
    repeat (hold) @(posedge sys_clk);
    {c, b, a} <= 3'b000;
    wait_rx(n);
  endtask

  // ============================================================
  // clock, monitors, timeout
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (rd_pend) chk("reg_rdata", rd_q.pop_front(), reg_rdata);
    rd_pend = reg_rd;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (rx_valid) begin
      rx_n++;
      if (check_on) chk("code word", exp_q.size() > 0 ? exp_q.pop_front() : 'x, rx_word);
    end
    if (gap_short && check_on) chk("guard gap", 0, 1);
    if (cyc > 95000) begin
      mismatches++;
      end_sim();
    end
  end

  // ============================================================
  // main sequence
  initial begin
    {a, b, c, trip_hi, trip_lo, reg_wr, reg_rd, shift, reg_addr, reg_wdata} = '0;
    {mismatches, checks, cyc, rx_n} = '0;
    te_cyc = 16'(TE);
    rst = 1'b1;
    check_on = 1'b1;
    rd_pend = 1'b0;
    void'($urandom(72));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(`HCWF_ADDR_CFG, `HCWF_CFG_RESET);
    {ser0, ser1, ekey} = {16'($urandom()), 16'($urandom()), 16'($urandom())};
    sync_v = 16'hfffd;
    cfg = {6'h03, 10'($urandom())};
    wr(`HCWF_ADDR_SER0, ser0);
    wr(`HCWF_ADDR_SER1, ser1);
    wr(`HCWF_ADDR_ENKEY, ekey);
    wr(`HCWF_ADDR_SYNC, sync_v);
    wr(4'h8, 16'hffff);
    rd(`HCWF_ADDR_SER1, ser1);
    rd(`HCWF_ADDR_ENKEY, ekey);
    rd(`HCWF_ADDR_SYNC, sync_v);
    rd(4'h8, 16'h0000);
    $display("registers done");
    for (int i = 0; i < 16; i++) begin
      cfg = {i[0], 2'b00, i[1], cfg[11:10], 10'($urandom())};
      trip_hi <= i[2];
      trip_lo <= !i[2];
      shift <= i[3:2];
      wr(`HCWF_ADDR_CFG, cfg);
      repeat (3) @(posedge sys_clk);
      chk("low battery flag", cfg[12] ? i[2] : !i[2], low_bat);
      word(i[1:0] == 2'b11 ? 3'b100 : 3'(i[1:0] + 1), i[3:0], 10, 1);
    end
    rd(`HCWF_ADDR_CFG, cfg);
    $display("function code table done");
    word(3'b001, 4'hc, 3300, 2);
    sync_v++;
    a <= 1'b1;
    repeat (230) @(posedge sys_clk);
    word(3'b011, 4'he, 10, 1);
    sync_v = 16'hffff;
    wr(`HCWF_ADDR_SYNC, sync_v);
    word(3'b001, 4'hc, 10, 1);
    word(3'b010, 4'hd, 10, 1);
    rd(`HCWF_ADDR_CFG, cfg);
    $display("repeat, abort and wrap done");
    // bench time is scaled like TE, so 150 cycles a half period sits far below the 20 kHz limit
    check_on = 1'b0;
    shift <= 2'd1;
    c <= 1'b1;
    repeat (40) @(posedge sys_clk);
    a <= 1'b1;
    @(posedge sys_clk);
    c <= 1'b0;
    // the c press, the a press and the entry itself each start a word
    sync_v += 3;
    exp82 = {16'h0000, exp_w(4'h4, 1'b0)};
    repeat (10) @(posedge sys_clk);
    a <= 1'b0;
    for (int k = 0; k < 83; k++) begin
      c <= 1'b1;
      repeat (150) @(posedge sys_clk);
      if (k < 82) got[k] = tx_data;
      c <= 1'b0;
      repeat (150) @(posedge sys_clk);
    end
    chk("sync mode word", exp82, got);
    // c was still high after the last rise, so one timed word runs before the block sleeps
    for (int w = 0; w < 3000 && awake !== 1'b0; w++) @(posedge sys_clk);
    chk("sync mode idle", 1'b0, awake);
    $display("sync mode done");
    for (int j = 1; j < 4; j++) begin
      cfg[14:13] = j[1:0];
      wr(`HCWF_ADDR_CFG, cfg);
      te_cyc <= 16'(TE >> (j == 1 ? 1 : 2));
      n = rx_n;
      a <= 1'b1;
      repeat (j == 1 ? 1600 : j == 2 ? 800 : 1900) @(posedge sys_clk);
      a <= 1'b0;
      wait_rx(n + 1);
    end
    $display("blanking done");
    end_sim();
  end
endmodule
`default_nettype wire
